// ===== shared/fault_crc_params.svh
// constants for the serial check and fault reporting block
`ifndef FAULT_CRC_PARAMS_SVH
`define FAULT_CRC_PARAMS_SVH

// crc: x^5 + x^4 + x^2 + 1, preset to all ones
`define CRC_POLY          5'h15
`define CRC_INIT          5'h1F
`define CRC_PAYLOAD_SHORT 5'h0B
`define CRC_PAYLOAD_REG   5'h13

// reply lengths per serial mode, in bits
`define REPLY_LEN_MODE0   5'h08
`define REPLY_LEN_MODE1   5'h10
`define REPLY_LEN_MODE2   5'h10
`define REPLY_LEN_MODE3   5'h18

// register addresses (bit 7 of the address byte marks a write)
`define ADDR_WRITE_BIT    7
`define ADDR_DRIVE        7'h00
`define ADDR_COLLECTIVE   7'h01
`define ADDR_GLOBAL_ERR   7'h02
`define ADDR_INTERNAL_ERR 7'h03
`define ADDR_CHAN_BASE    4'h1

// error register field positions
`define GLOBAL_ERROR_REG_UV_BIT      0
`define GLOBAL_ERROR_REG_MV_BIT      1
`define INTERNAL_ERROR_REG_TE_BIT     0
`define INTERNAL_ERROR_REG_W4P_BIT    1

// reset values
`define FLAG_RESET        4'hF
`define DRIVE_RESET       8'h00

// persistence of transfer errors before the power side counts as lost
`define W4P_TIME_US       1000
`define CLK_FREQ_MHZ      100

`endif

// ===== shared/fault_crc_pkg.sv
// types and crc arithmetic for the serial check and fault reporting block
`include "fault_crc_params.svh"

package fault_crc_pkg;

   typedef enum logic [2:0]
   {
      MODE_SER0,
      MODE_SER1,
      MODE_SER2,
      MODE_SER3,
      MODE_PAR_SINGLE,
      MODE_PAR_REPEAT,
      MODE_PAR_DIRECT
   } iface_mode_t;

   typedef struct packed
   {
      logic uv;
      logic mv;
      logic te;
      logic w4p;
   } status_flags_t;

   typedef struct packed
   {
      logic uv;
      logic mv;
      logic te;
   } supply_src_t;

   // one serial step of the 5-bit crc
   function automatic logic [4:0] crc_step(input logic [4:0] r,
                                           input logic       d);
      logic fb;
      fb = r[4] ^ d;
      crc_step = {r[3:0], 1'b0} ^ (fb ? `CRC_POLY : 5'h00);
   endfunction : crc_step

   // crc over the lowest len bits of data, most significant first
   function automatic logic [4:0] crc_over(input logic [18:0] data,
                                           input logic [4:0]  len);
      logic [4:0] r;
      logic [4:0] k;
      r = `CRC_INIT;
      for (int i = 0; i < 19; i++)
      begin
         k = 5'(len - 5'h01 - 5'(i));
         if (5'(i) < len)
            r = crc_step(r, data[k]);
      end
      crc_over = r;
   endfunction : crc_over

endpackage : fault_crc_pkg

// ===== core/level_sync.sv
// two-flop synchroniser for a group of slow levels
`timescale 1ns/1ns
`default_nettype none

module level_sync
(
   input  wire logic       clk,     // destination clock
   input  wire logic       rst_n,   // active-low reset
   input  wire logic [6:0] d,       // asynchronous levels
   output logic      [6:0] q        // synchronised levels
);

   logic [6:0] meta_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= 7'h00;
         q        <= 7'h00;
      end
      else
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule : level_sync

`default_nettype wire

// ===== core/crc5_engine.sv
// serial 5-bit crc checker, restartable on any bit
`timescale 1ns/1ns
`default_nettype none
`include "fault_crc_params.svh"

module crc5_engine
(
   input  wire logic       clk,      // shift clock
   input  wire logic       rst_n,    // active-low reset
   input  wire logic       restart,  // this bit opens a new block
   input  wire logic       din,      // serial data bit
   output logic      [4:0] rem       // running remainder
);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rem <= `CRC_INIT;
      else if (restart)
         rem <= fault_crc_pkg::crc_step(`CRC_INIT, din);
      else
         rem <= fault_crc_pkg::crc_step(rem, din);
   end

endmodule : crc5_engine

`default_nettype wire

// ===== core/fault_crc_top.sv
// serial frame checking, status telegram and fault pin reporting
`timescale 1ns/1ns
`default_nettype none
`include "fault_crc_params.svh"

module fault_crc_top
#(
   parameter int unsigned W4P_CYCLES = `W4P_TIME_US * `CLK_FREQ_MHZ
)
(
   input  wire logic        clk_sys,             // system clock
   input  wire logic        resetn,              // supply lockout, low
   input  wire logic        sclk,                // serial clock
   input  wire logic        cs_n,                // chip select, low
   input  wire logic        sdi,                 // serial data in
   output logic             sdo_o,               // serial data out
   output logic             sdo_oe,              // serial out enable
   input  wire logic        serial_select,       // 1 serial, 0 parallel
   input  wire logic        mode_select_lo,      // serial mode bit 0
   input  wire logic        mode_select_hi,      // serial mode bit 1
   input  wire logic [1:0]  parallel_submode,    // 0 single 1 rep 2 dir
   input  wire logic        sync_in,             // synchronisation pin
   input  wire logic        diag_freeze_enable,  // freeze on sync edges
   input  wire logic        par_read_strobe,     // parallel read pulse
   input  wire logic [6:0]  par_read_addr,       // parallel read address
   output logic      [7:0]  par_read_data,       // parallel read data
   input  wire fault_crc_pkg::supply_src_t supply_src, // live faults
   input  wire logic [7:0]  channel_gated_status_bits, // volatile
   input  wire logic [63:0] diag_src,            // 8 bits per channel
   output logic      [7:0]  drive_out,           // output drive byte
   output logic             check_error_n_o,     // always 0
   output logic             check_error_n_oe,    // pulls pin low
   output logic             err_n_o,             // always 0
   output logic             err_n_oe             // pulls pin low
);

   logic                        rst_meta_reg;
   logic                        rst_n;
   logic [6:0]                  pins_s;
   logic                        cs_s;
   logic                        cs_d_reg;
   logic                        sync_d_reg;
   logic                        cs_rise;
   logic                        cs_fall;
   fault_crc_pkg::iface_mode_t  mode_reg;
   fault_crc_pkg::iface_mode_t  mode_next;
   // link side
   logic                        fresh_reg;
   logic [5:0]                  bit_cnt_reg;
   logic [23:0]                 in_shift_reg;
   logic                        frame_tog_reg;
   logic                        share_restart;
   logic [4:0]                  share_rem;
   logic [4:0]                  full_rem;
   logic [5:0]                  neg_idx_reg;
   logic [5:0]                  idx_next;
   logic                        started_reg;
   logic                        sdo_reg;
   // system side
   logic                        snap_tog_reg;
   logic [23:0]                 tx_word_reg;
   logic [4:0]                  tx_len_reg;
   logic [23:0]                 tx_word_next;
   logic [4:0]                  tx_len_next;
   logic                        clocked;
   logic                        count_bad;
   logic                        crc_bad;
   logic                        frame_ok;
   logic [7:0]                  spi_addr;
   logic [7:0]                  spi_data;
   logic                        spi_reg_mode;
   logic [6:0]                  rd_addr;
   logic                        rd_valid;
   logic                        coll_rd;
   logic                        global_error_reg_rd;
   logic                        internal_error_reg_rd;
   logic                        auto_clear;
   logic                        freeze_hold;
   logic                        sync_edge;
   logic [7:0]                  read_data_reg;
   logic [63:0]                 diag_sticky_reg;
   logic [7:0]                  collective_diag_reg;
   logic [7:0]                  channel_diag_reg [0:7];
   logic                        common_fault_flag;
   fault_crc_pkg::status_flags_t flags_reg;
   fault_crc_pkg::status_flags_t flags_set;
   logic [16:0]                 te_cnt_reg;
   logic                        wait_power_side_flag;
   logic                        direct_mode_output_fault;
   logic                        fault;
   logic                        check_err_reg;
   logic                        err_reg;

   // reset release through two flops
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   level_sync u_pin_sync
   (
      .clk   (clk_sys),
      .rst_n (rst_n),
      .d     ({sync_in, parallel_submode, serial_select,
               mode_select_hi, mode_select_lo, ~cs_n}),
      .q     (pins_s)
   );

   assign cs_s      = ~pins_s[0];
   assign cs_rise   = cs_s & ~cs_d_reg;
   assign cs_fall   = ~cs_s & cs_d_reg;
   assign sync_edge = pins_s[6] ^ sync_d_reg;

   always_comb
   begin
      if (pins_s[3])
         mode_next = fault_crc_pkg::iface_mode_t'({1'b0, pins_s[2:1]});
      else if (pins_s[5:4] == 2'h2)
         mode_next = fault_crc_pkg::MODE_PAR_DIRECT;
      else if (pins_s[5:4] == 2'h1)
         mode_next = fault_crc_pkg::MODE_PAR_REPEAT;
      else
         mode_next = fault_crc_pkg::MODE_PAR_SINGLE;
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cs_d_reg   <= 1'b1;
         sync_d_reg <= 1'b0;
         mode_reg   <= fault_crc_pkg::MODE_PAR_SINGLE;
      end
      else
      begin
         cs_d_reg   <= cs_s;
         sync_d_reg <= pins_s[6];
         mode_reg   <= mode_next;
      end
   end

   // link side, serial clock domain
   // first edge of a frame is marked while chip select is high
   always_ff @(posedge sclk or negedge rst_n or posedge cs_n)
   begin
      if (!rst_n)
         fresh_reg <= 1'b1;
      else if (cs_n)
         fresh_reg <= 1'b1;
      else
         fresh_reg <= 1'b0;
   end

   always_ff @(posedge sclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bit_cnt_reg   <= 6'h00;
         in_shift_reg  <= 24'h000000;
         frame_tog_reg <= 1'b0;
      end
      else if (fresh_reg)
      begin
         bit_cnt_reg   <= 6'h01;
         in_shift_reg  <= {23'h000000, sdi};
         frame_tog_reg <= ~frame_tog_reg;
      end
      else
      begin
         bit_cnt_reg   <= bit_cnt_reg + 6'h01;
         in_shift_reg  <= {in_shift_reg[22:0], sdi};
      end
   end

   assign share_restart = fresh_reg | (bit_cnt_reg[3:0] == 4'h0);

   crc5_engine u_share_check
   (
      .clk     (sclk),
      .rst_n   (rst_n),
      .restart (share_restart),
      .din     (sdi),
      .rem     (share_rem)
   );

   crc5_engine u_full_check
   (
      .clk     (sclk),
      .rst_n   (rst_n),
      .restart (fresh_reg),
      .din     (sdi),
      .rem     (full_rem)
   );

   assign idx_next = (neg_idx_reg == 6'h3F) ? neg_idx_reg
                                            : neg_idx_reg + 6'h01;

   // reply bits, then the chained stream
   always_ff @(negedge sclk or negedge rst_n or posedge cs_n)
   begin
      if (!rst_n || cs_n)
      begin
         neg_idx_reg <= 6'h00;
         started_reg <= 1'b0;
         sdo_reg     <= 1'b0;
      end
      else
      begin
         neg_idx_reg <= idx_next;
         started_reg <= 1'b1;
         if (idx_next < {1'b0, tx_len_reg})
            sdo_reg <= tx_word_reg[5'h17 - idx_next[4:0]];
         else
            sdo_reg <= in_shift_reg[tx_len_reg - 5'h01];
      end
   end

   // first bit shows on select
   assign sdo_o  = started_reg ? sdo_reg : tx_word_reg[23];
   assign sdo_oe = ~cs_n;

   // system side
   assign clocked   = frame_tog_reg != snap_tog_reg;
   assign count_bad = clocked & (bit_cnt_reg[2:0] != 3'h0);
   always_comb
   begin
      crc_bad = 1'b0;
      if (mode_reg == fault_crc_pkg::MODE_SER1)
         crc_bad = clocked & (share_rem != 5'h00);
      else if (mode_reg == fault_crc_pkg::MODE_SER3)
         crc_bad = clocked & (full_rem != 5'h00);
   end
   assign frame_ok = cs_rise & clocked & ~count_bad & ~crc_bad
                     & ~pins_s[3] == 1'b0;

   assign spi_reg_mode = (mode_reg == fault_crc_pkg::MODE_SER2)
                       | (mode_reg == fault_crc_pkg::MODE_SER3);
   assign spi_addr = (mode_reg == fault_crc_pkg::MODE_SER3)
                   ? in_shift_reg[23:16] : in_shift_reg[15:8];
   assign spi_data = (mode_reg == fault_crc_pkg::MODE_SER3)
                   ? in_shift_reg[15:8] : in_shift_reg[7:0];
   assign auto_clear = frame_ok
                     & ((mode_reg == fault_crc_pkg::MODE_SER0)
                      | (mode_reg == fault_crc_pkg::MODE_SER1));

   always_comb
   begin
      rd_valid = 1'b0;
      rd_addr  = par_read_addr;
      if (frame_ok & spi_reg_mode & ~spi_addr[`ADDR_WRITE_BIT])
      begin
         rd_valid = 1'b1;
         rd_addr  = spi_addr[6:0];
      end
      else if (par_read_strobe & ~mode_reg[2] == 1'b0
               & (mode_reg != fault_crc_pkg::MODE_PAR_DIRECT))
         rd_valid = 1'b1;
   end

   assign coll_rd   = (rd_valid & (rd_addr == `ADDR_COLLECTIVE))
                    | auto_clear;
   assign global_error_reg_rd  = (rd_valid & (rd_addr == `ADDR_GLOBAL_ERR))
                    | auto_clear;
   assign internal_error_reg_rd = (rd_valid & (rd_addr == `ADDR_INTERNAL_ERR))
                    | auto_clear;

   function automatic logic [7:0] reg_read(input logic [6:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == `ADDR_DRIVE)
         v = drive_out;
      else if (a == `ADDR_COLLECTIVE)
         v = collective_diag_reg;
      else if (a == `ADDR_GLOBAL_ERR)
      begin
         v[`GLOBAL_ERROR_REG_UV_BIT] = flags_reg.uv;
         v[`GLOBAL_ERROR_REG_MV_BIT] = flags_reg.mv;
      end
      else if (a == `ADDR_INTERNAL_ERR)
      begin
         v[`INTERNAL_ERROR_REG_TE_BIT]  = flags_reg.te;
         v[`INTERNAL_ERROR_REG_W4P_BIT] = flags_reg.w4p;
      end
      else if (a[6:3] == `ADDR_CHAN_BASE)
         v = channel_diag_reg[a[2:0]];
      reg_read = v;
   endfunction : reg_read

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         snap_tog_reg  <= 1'b0;
         check_err_reg <= 1'b0;
      end
      else
      begin
         if (cs_fall)
            snap_tog_reg <= frame_tog_reg;
         if (cs_rise)
            check_err_reg <= ~mode_reg[2] & (count_bad | crc_bad);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         drive_out     <= `DRIVE_RESET;
         read_data_reg <= 8'h00;
         par_read_data <= 8'h00;
      end
      else
      begin
         if (frame_ok & (mode_reg == fault_crc_pkg::MODE_SER0))
            drive_out <= in_shift_reg[7:0];
         else if (frame_ok & (mode_reg == fault_crc_pkg::MODE_SER1))
            drive_out <= in_shift_reg[15:8];
         else if (frame_ok & spi_reg_mode & spi_addr[`ADDR_WRITE_BIT]
                  & (spi_addr[6:0] == `ADDR_DRIVE))
            drive_out <= spi_data;
         if (frame_ok & spi_reg_mode)
            read_data_reg <= spi_addr[`ADDR_WRITE_BIT] ? 8'h00
                                                      : reg_read(rd_addr);
         if (par_read_strobe)
            par_read_data <= reg_read(par_read_addr);
      end
   end

   // diagnostics
   assign freeze_hold = diag_freeze_enable & ~pins_s[6];

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         diag_sticky_reg <= 64'h0000000000000000;
      else
         diag_sticky_reg <= diag_src
                          | (coll_rd ? 64'h0000000000000000
                                     : diag_sticky_reg);
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         collective_diag_reg <= 8'h00;
      else if (!freeze_hold)
         for (int c = 0; c < 8; c++)
            collective_diag_reg[c] <= |diag_sticky_reg[c*8 +: 8];
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int c = 0; c < 8; c++)
            channel_diag_reg[c] <= 8'h00;
      end
      else if ((coll_rd & ~freeze_hold)
               | (diag_freeze_enable & sync_edge))
      begin
         for (int c = 0; c < 8; c++)
            channel_diag_reg[c] <= diag_sticky_reg[c*8 +: 8];
      end
   end

   assign common_fault_flag = |collective_diag_reg;

   // status flags and fault pin
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         te_cnt_reg <= 17'h00000;
      else if (!supply_src.te)
         te_cnt_reg <= 17'h00000;
      else if (te_cnt_reg != W4P_CYCLES[16:0])
         te_cnt_reg <= te_cnt_reg + 17'h00001;
   end

   assign wait_power_side_flag = te_cnt_reg == W4P_CYCLES[16:0];
   assign flags_set = {supply_src.uv, supply_src.mv, supply_src.te,
                       wait_power_side_flag};

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         flags_reg <= `FLAG_RESET;
      else
      begin
         flags_reg.uv  <= flags_set.uv  | (flags_reg.uv  & ~global_error_reg_rd);
         flags_reg.mv  <= flags_set.mv  | (flags_reg.mv  & ~global_error_reg_rd);
         flags_reg.te  <= flags_set.te  | (flags_reg.te  & ~internal_error_reg_rd);
         flags_reg.w4p <= flags_set.w4p | (flags_reg.w4p & ~internal_error_reg_rd);
      end
   end

   assign direct_mode_output_fault = |channel_gated_status_bits;

   always_comb
   begin
      case (mode_reg)
         fault_crc_pkg::MODE_PAR_DIRECT:
            fault = direct_mode_output_fault | wait_power_side_flag;
         fault_crc_pkg::MODE_PAR_SINGLE,
         fault_crc_pkg::MODE_PAR_REPEAT:
            fault = (|flags_reg) | common_fault_flag;
         default:
            fault = |flags_reg;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         err_reg <= 1'b1;
      else
         err_reg <= fault;
   end

   // reply telegram, held steady while selected
   always_comb
   begin
      tx_word_next = {collective_diag_reg, 16'h0000};
      tx_len_next  = `REPLY_LEN_MODE0;
      case (mode_reg)
         fault_crc_pkg::MODE_SER1:
         begin
            tx_word_next[23:13] = {collective_diag_reg, flags_reg.uv,
                                   flags_reg.mv, common_fault_flag};
            tx_word_next[12:8]  = fault_crc_pkg::crc_over(
               {8'h00, tx_word_next[23:13]}, `CRC_PAYLOAD_SHORT);
            tx_len_next = `REPLY_LEN_MODE1;
         end
         fault_crc_pkg::MODE_SER2:
         begin
            tx_word_next[15:8] = read_data_reg;
            tx_len_next = `REPLY_LEN_MODE2;
         end
         fault_crc_pkg::MODE_SER3:
         begin
            tx_word_next[23:5] = {collective_diag_reg, read_data_reg,
                                  flags_reg.uv, flags_reg.mv,
                                  common_fault_flag};
            tx_word_next[4:0]  = fault_crc_pkg::crc_over(
               tx_word_next[23:5], `CRC_PAYLOAD_REG);
            tx_len_next = `REPLY_LEN_MODE3;
         end
         default:
            tx_len_next = `REPLY_LEN_MODE0;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_word_reg <= 24'h000000;
         tx_len_reg  <= `REPLY_LEN_MODE0;
      end
      else if (cs_s & cs_d_reg & cs_n)
      begin
         tx_word_reg <= tx_word_next;
         tx_len_reg  <= tx_len_next;
      end
   end

   assign check_error_n_o  = 1'b0;
   assign check_error_n_oe = check_err_reg;
   assign err_n_o          = 1'b0;
   assign err_n_oe         = err_reg;

endmodule : fault_crc_top

`default_nettype wire

// ===== verification/fault_crc_top_checker.sv
// port assertions for the fault block
`timescale 1ns/1ns
`default_nettype none
module fault_crc_top_checker
(
   input wire logic        clk_sys,          // clock
   input wire logic        resetn,           // reset
   input wire logic        cs_n,             // select
   input wire logic        sdo_oe,           // out enable
   input wire logic        serial_select,    // serial
   input wire logic [1:0]  parallel_submode, // submode
   input wire fault_crc_pkg::supply_src_t supply_src, // faults
   input wire logic [7:0]  channel_gated_status_bits, // gated
   input wire logic [63:0] diag_src,         // events
   input wire logic        par_read_strobe,  // strobe
   input wire logic [7:0]  par_read_data,    // read data
   input wire logic [7:0]  drive_out,        // drive
   input wire logic        check_error_n_oe, // check pin
   input wire logic        err_n_oe          // fault pin
);
   logic [3:0] hi_cnt;
   logic       dir;
   assign dir = !serial_select && parallel_submode == 2'h2;
   always_ff @(posedge clk_sys or negedge resetn)
      if (!resetn)
         hi_cnt <= 4'hF;
      else if (!cs_n)
         hi_cnt <= 4'h0;
      else if (hi_cnt != 4'hF)
         hi_cnt <= hi_cnt + 4'h1;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   a_out_enable_select: assert property (sdo_oe == !cs_n)
      else $error("sdo enable off");
   a_check_at_rise: assert property (
      $changed(check_error_n_oe) |-> hi_cnt inside {[4'h2:4'h6]})
      else $error("check error off rise");
   a_drive_at_rise: assert property (
      $changed(drive_out) |-> hi_cnt inside {[4'h2:4'h6]})
      else $error("drive off rise");
   a_sticky_src_pin: assert property (
      (supply_src != 3'h0 && !dir) [*8] |-> err_n_oe)
      else $error("supply fault hidden");
   a_common_fault_pin: assert property (
      (!serial_select && parallel_submode == 2'h0 && |diag_src) [*8]
      |-> err_n_oe) else $error("common fault hidden");
   a_direct_gated_pin: assert property (
      (dir && |channel_gated_status_bits) [*8] |-> err_n_oe)
      else $error("gated fault hidden");
   a_direct_clear_pin: assert property (
      (dir && channel_gated_status_bits == 8'h00 && !supply_src.te) [*8]
      |-> !err_n_oe) else $error("fault pin stuck");
   a_read_data_holds: assert property (
      !par_read_strobe && !$past(par_read_strobe) |-> $stable(par_read_data))
      else $error("read data moved");
   c_check_error: cover property ($rose(check_error_n_oe));
   c_drive_write: cover property ($changed(drive_out));
   c_fault_clear: cover property ($fell(err_n_oe));
endmodule : fault_crc_top_checker
bind fault_crc_top fault_crc_top_checker chk
(
   .clk_sys(clk_sys), .resetn(resetn), .cs_n(cs_n), .sdo_oe(sdo_oe),
   .serial_select(serial_select), .parallel_submode(parallel_submode),
   .supply_src(supply_src), .diag_src(diag_src),
   .channel_gated_status_bits(channel_gated_status_bits),
   .par_read_strobe(par_read_strobe), .par_read_data(par_read_data),
   .drive_out(drive_out), .check_error_n_oe(check_error_n_oe),
   .err_n_oe(err_n_oe)
);
`default_nettype wire

// ===== verification/spi_master_model.sv
// serial master model
`timescale 1ns/1ns
`default_nettype none
module spi_master_model
(
   output logic      sclk,   // serial clock
   output logic      cs_n,   // chip select
   output logic      sdi,    // data to block
   input  wire logic sdo_o   // data from block
);
   initial {sclk, cs_n, sdi} = 3'h2;
   task automatic xfer(input logic [31:0] w, input int n,
                       output logic [31:0] rx);
      rx = 32'h0;
      cs_n = 1'b0;
      #40;
      for (int i = n - 1; i >= 0; i--)
      begin
         sdi = w[i];
         #80 sclk = 1'b1;
         rx = {rx[30:0], sdo_o};
         #80 sclk = 1'b0;
      end
      #40 cs_n = 1'b1;
      sdi = 1'b0;
      #80;
   endtask : xfer
   task automatic stray(input int n);
      repeat (n)
      begin
         #80 sclk = 1'b1;
         #80 sclk = 1'b0;
      end
   endtask : stray
endmodule : spi_master_model
`default_nettype wire

// ===== verification/fault_crc_top_test.sv
// bench for the fault reporting block
`timescale 1ns/1ns
`default_nettype none
module fault_crc_top_test;
   logic        clk_sys, resetn, sclk, cs_n, sdi, sdo_o, sdo_oe;
   logic        ser, m_lo, m_hi, strobe, ce_o, ce_oe, er_o, er_oe;
   logic [1:0]  sub;
   logic [6:0]  addr;
   logic [7:0]  rdata, gated, drive, b;
   logic [63:0] diag;
   logic [31:0] rx;
   fault_crc_pkg::supply_src_t src;
   int          n_mismatch, tests_run, seed;
   fault_crc_top #(.W4P_CYCLES(20)) DUT
   (
      .clk_sys(clk_sys), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
      .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .serial_select(ser),
      .mode_select_lo(m_lo), .mode_select_hi(m_hi),
      .parallel_submode(sub), .sync_in(1'b1), .diag_freeze_enable(1'b0),
      .par_read_strobe(strobe), .par_read_addr(addr),
      .par_read_data(rdata), .supply_src(src),
      .channel_gated_status_bits(gated), .diag_src(diag),
      .drive_out(drive), .check_error_n_o(ce_o),
      .check_error_n_oe(ce_oe), .err_n_o(er_o), .err_n_oe(er_oe)
   );
   spi_master_model master
   (
      .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_o(sdo_o)
   );
   always #5 clk_sys = ~clk_sys;
   function automatic logic [4:0] crc5(input logic [18:0] d, input int n);
      logic [4:0] r;
      r = 5'h1F;
      for (int i = n - 1; i >= 0; i--)
         r = {r[3:0], 1'b0} ^ ((r[4] ^ d[i]) ? 5'h15 : 5'h00);
      return r;
   endfunction : crc5
   function automatic logic [15:0] s1(input logic [7:0] d);
      return {d, 3'h0, crc5({8'h00, d, 3'h0}, 11)};
   endfunction : s1
   function automatic logic [23:0] s3(input logic [7:0] a, d);
      return {a, d, 3'h0, crc5({a, d, 3'h0}, 19)};
   endfunction : s3
   task automatic check(input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch %0t: got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic conclude();
      $display("runs %0d errors %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   task automatic frame(input logic [31:0] w, input int n);
      master.xfer(w, n, rx);
      hold(8);
   endtask : frame
   // {ser, hi, lo, sub}
   task automatic mode(input logic [4:0] v);
      @(negedge clk_sys);
      {ser, m_hi, m_lo, sub} = v;
      repeat (6) @(negedge clk_sys);
   endtask : mode
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      {strobe, addr} = {1'b1, a};
      @(negedge clk_sys);
      strobe = 1'b0;
      @(negedge clk_sys);
      d = rdata;
   endtask : rd
   task automatic hold(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : hold
   initial
   begin
      #500000;
      n_mismatch++;
      conclude();
   end
   initial
   begin
      {clk_sys, resetn, ser, m_lo, m_hi, strobe, sub, addr} = 15'h0;
      {gated, diag, src} = 75'h0;
      {seed, n_mismatch, tests_run} = {32'd1243, 64'd0};
      hold(16);
      resetn = 1'b1;
      hold(8);
      check(er_oe, 1'b1);
      mode(5'h10);
      frame(32'hA5, 8);
      check(drive, 8'hA5);
      check(er_oe, 1'b0);
      diag[29] = 1'b1;
      hold(8);
      check(er_oe, 1'b0);
      diag = 64'h0;
      mode(5'h14);
      repeat (6)
      begin
         b = 8'($random(seed));
         frame(s1(b), 16);
         check(drive, b);
         check(ce_oe, 1'b0);
         check(rx[4:0], crc5(19'(rx[15:5]), 11));
      end
      master.stray(5);
      hold(8);
      check(ce_oe, 1'b0);
      frame(s1(~b) ^ 16'h0001, 16);
      check(ce_oe, 1'b1);
      check(drive, b);
      hold(8);
      check(ce_oe, 1'b1);
      frame({s1(8'hC3) ^ 16'h0001, s1(8'h3C)}, 32);
      check({ce_oe, drive}, 9'h03C);
      frame(32'h0, 12);
      check({ce_oe, drive}, 9'h13C);
      mode(5'h1C);
      frame(s3(8'h80, 8'h5A), 24);
      check({ce_oe, drive}, 9'h05A);
      frame(s3(8'h01, 8'h00), 24);
      check(rx[4:0], crc5(rx[23:5], 19));
      mode(5'h18);
      src.te = 1'b1;
      hold(10);
      src.te = 1'b0;
      frame(32'h8033, 16);
      check({er_oe, drive}, 9'h133);
      frame(32'h0300, 16);
      check(er_oe, 1'b0);
      mode(5'h00);
      diag[29] = 1'b1;
      hold(10);
      diag = 64'h0;
      check(er_oe, 1'b1);
      rd(7'h01, b);
      check(b, 8'h08);
      rd(7'h0B, b);
      check(b, 8'h20);
      rd(7'h01, b);
      check({er_oe, b}, 9'h000);
      mode(5'h02);
      repeat (4)
      begin
         gated = 8'($random(seed)) | 8'h01;
         hold(10);
         check(er_oe, 1'b1);
         gated = 8'h00;
         src = 3'h4;
         hold(10);
         check(er_oe, 1'b0);
         src = 3'h0;
      end
      src.te = 1'b1;
      hold(40);
      check(er_oe, 1'b1);
      conclude();
   end
endmodule : fault_crc_top_test
`default_nettype wire
